// *** logic/iou_output_unit.v ***
// Purpose: turns the internal gyro/accel sample stream into output words
// Assumes: sensor inputs sampled on the internal tick, synchronous inputs
// Notes: words go out as parallel registers and as a six-byte stream
`timescale 1ns/1ps
`include "iou_defs.vh"
module iou_output_unit #(
  parameter SAMPLE_CYCLES = `IOU_SAMPLE_CYCLES,
  parameter DELAY_SAMPLES = `IOU_DELAY_SAMPLES
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [23:0] gyroSample,
  input wire [23:0] accSample,
  input wire [3:0] gyroUnit,
  input wire accUnit,
  input wire [3:0] lpfShift,
  input wire txStrobe,
  output reg sampleTick_q,
  output reg [23:0] gyroWord_q,
  output reg [23:0] accWord_q,
  output reg wordValid_q,
  output reg [7:0] outByte_q,
  output reg outByteValid_q,
  output reg [2:0] outByteIdx_q
);
  localparam CW = $clog2(SAMPLE_CYCLES);
  localparam AW = 40;

  ////////////////////////////////////////////////////////////////////////
  // internal sample timer
  reg [CW-1:0] tickCnt_q;
  wire tickNow = (tickCnt_q == SAMPLE_CYCLES - 1);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tickCnt_q <= {CW{1'b0}};
      sampleTick_q <= 1'b0;
    end else begin
      tickCnt_q <= tickNow ? {CW{1'b0}} : tickCnt_q + {{(CW-1){1'b0}}, 1'b1};
      sampleTick_q <= tickNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stage 1: optional 5 ms gyro delay, accel captured alongside
  wire [23:0] delayed;
  reg s1Valid_q;
  reg [23:0] gyroRaw_q;
  reg [23:0] accS1_q;
  wire delayOn = gyroUnit[`IOU_GYRO_DELAY_BIT];

  iou_delay_mem #(
    .WIDTH(24),
    .DEPTH(DELAY_SAMPLES)
  ) uDelay (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wrEn(tickNow),
    .wrData(gyroSample),
    .rdData(delayed)
  );

  // mem output lands one cycle after the tick, like these registers
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s1Valid_q <= 1'b0;
      gyroRaw_q <= 24'h000000;
      accS1_q <= 24'h000000;
    end else begin
      s1Valid_q <= tickNow;
      if (tickNow) begin
        gyroRaw_q <= gyroSample;
        accS1_q <= accSample;
      end
    end
  end

  wire [23:0] gyroSel = delayOn ? delayed : gyroRaw_q;

  ////////////////////////////////////////////////////////////////////////
  // stage 2: one-pole low-pass, shift 0 passes the sample through
  reg s2Valid_q;
  reg signed [23:0] filt_q;
  reg signed [23:0] accS2_q;
  wire signed [24:0] filtDiff = $signed({gyroSel[23], gyroSel}) -
    $signed({filt_q[23], filt_q});
  wire signed [24:0] filtStep = filtDiff >>> lpfShift;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s2Valid_q <= 1'b0;
      filt_q <= 24'sh000000;
      accS2_q <= 24'sh000000;
    end else begin
      s2Valid_q <= s1Valid_q;
      if (s1Valid_q) begin
        filt_q <= filt_q + filtStep[23:0];
        accS2_q <= accS1_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-sample scaled contributions in Q16 below the output lsb
  wire signed [40:0] angProd = filt_q * $signed({1'b0, `IOU_ANGLE_K});
  wire signed [40:0] velProd = accS2_q * $signed({1'b0, `IOU_VEL_K});
  wire signed [AW-1:0] angInc = angProd[AW-1:0];
  wire signed [AW-1:0] velInc = velProd[AW-1:0];
  wire signed [31:0] rateExt = {{8{filt_q[23]}}, filt_q};
  wire signed [31:0] accExt = {{8{accS2_q[23]}}, accS2_q};

  // accumulators
  reg signed [AW-1:0] incAng_q;
  reg signed [AW-1:0] intAng_q;
  reg signed [AW-1:0] incVel_q;
  reg signed [31:0] rateSum_q;
  reg signed [31:0] accSum_q;
  reg [4:0] count_q;

  // a sample landing with the transmit opens the next period
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      incAng_q <= {AW{1'b0}};
      intAng_q <= {AW{1'b0}};
      incVel_q <= {AW{1'b0}};
      rateSum_q <= 32'h00000000;
      accSum_q <= 32'h00000000;
      count_q <= 5'h00;
    end else begin
      if (s2Valid_q) begin
        // 40-bit total wraps at +-4 deg with no flag raised
        intAng_q <= intAng_q + angInc;
      end
      if (txStrobe) begin
        // per-transmit sums restart
        incAng_q <= s2Valid_q ? angInc : {AW{1'b0}};
        incVel_q <= s2Valid_q ? velInc : {AW{1'b0}};
        rateSum_q <= s2Valid_q ? rateExt : 32'h00000000;
        accSum_q <= s2Valid_q ? accExt : 32'h00000000;
        count_q <= s2Valid_q ? 5'h01 : 5'h00;
      end else if (s2Valid_q) begin
        incAng_q <= incAng_q + angInc;
        incVel_q <= incVel_q + velInc;
        rateSum_q <= rateSum_q + rateExt;
        accSum_q <= accSum_q + accExt;
        // saturate so an idle link cannot wrap the count
        if (count_q != 5'h1F) begin
          count_q <= count_q + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // averaging divides by the power-of-two sample counts of the legal
  // rates (1,2,4,8,16); other counts round down to the next power
  reg [2:0] avgShift;
  always @* begin
    if (count_q >= 5'h10) begin
      avgShift = 3'h4;
    end else if (count_q >= 5'h08) begin
      avgShift = 3'h3;
    end else if (count_q >= 5'h04) begin
      avgShift = 3'h2;
    end else if (count_q >= 5'h02) begin
      avgShift = 3'h1;
    end else begin
      avgShift = 3'h0;
    end
  end

  wire signed [31:0] rateAvg = rateSum_q >>> avgShift;
  wire signed [31:0] accAvg = accSum_q >>> avgShift;

  // gyro function select
  reg [23:0] gyroNext;
  always @* begin
    case (gyroUnit[1:0])
      `IOU_GYRO_RATE: gyroNext = filt_q;
      `IOU_GYRO_INCR: gyroNext = incAng_q[AW-1:`IOU_K_SHIFT];
      `IOU_GYRO_AVG: gyroNext = rateAvg[23:0];
      `IOU_GYRO_INTEG: gyroNext = intAng_q[AW-1:`IOU_K_SHIFT];
      default: gyroNext = filt_q;
    endcase
  end

  wire [23:0] accNext = (accUnit == `IOU_ACC_AVG) ? accAvg[23:0] :
    incVel_q[AW-1:`IOU_K_SHIFT];

  ////////////////////////////////////////////////////////////////////////
  // word latch and byte stream: gyro then accel, high byte first
  reg [2:0] byteLeft_q;
  reg [39:0] shift_q;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      gyroWord_q <= 24'h000000;
      accWord_q <= 24'h000000;
      wordValid_q <= 1'b0;
      outByte_q <= 8'h00;
      outByteValid_q <= 1'b0;
      outByteIdx_q <= 3'h0;
      byteLeft_q <= 3'h0;
      shift_q <= 40'h0000000000;
    end else begin
      wordValid_q <= txStrobe;
      if (txStrobe) begin
        // a new transmit restarts the stream
        gyroWord_q <= gyroNext;
        accWord_q <= accNext;
        outByte_q <= gyroNext[`IOU_BYTE_HI];
        outByteValid_q <= 1'b1;
        outByteIdx_q <= 3'h0;
        shift_q <= {gyroNext[`IOU_BYTE_MID], gyroNext[`IOU_BYTE_LO],
          accNext};
        byteLeft_q <= 3'h5;
      end else if (byteLeft_q != 3'h0) begin
        outByte_q <= shift_q[39:32];
        outByteValid_q <= 1'b1;
        outByteIdx_q <= outByteIdx_q + 3'h1;
        shift_q <= {shift_q[31:0], 8'h00};
        byteLeft_q <= byteLeft_q - 3'h1;
      end else begin
        outByteValid_q <= 1'b0;
      end
    end
  end
endmodule // iou_output_unit

// *** logic/iou_defs.vh ***
// Purpose: shared constants of the output-unit processing block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef IOU_DEFS_VH
`define IOU_DEFS_VH

// clock and sample timing
`define IOU_CLK_HZ 50000000
`define IOU_SAMPLE_RATE_HZ 2000
`define IOU_SAMPLE_CYCLES (`IOU_CLK_HZ / `IOU_SAMPLE_RATE_HZ)
`define IOU_DELAY_MS 5
`define IOU_DELAY_SAMPLES (`IOU_SAMPLE_RATE_HZ * `IOU_DELAY_MS / 1000)

// word layout
`define IOU_WORD_W 24
`define IOU_BYTE_HI 23:16
`define IOU_BYTE_MID 15:8
`define IOU_BYTE_LO 7:0

// gyro unit code: bits 1:0 select function, bit 3 enables the delay
`define IOU_GYRO_RATE 2'h0
`define IOU_GYRO_INCR 2'h1
`define IOU_GYRO_AVG 2'h2
`define IOU_GYRO_INTEG 2'h3
`define IOU_GYRO_DELAY_BIT 3

// accelerometer unit code
`define IOU_ACC_INCR 1'h0
`define IOU_ACC_AVG 1'h1

// rate (2^-14 deg/s) to angle (2^-21 deg) per sample: 128/2000 in Q16
`define IOU_ANGLE_K 16'h1062
// accel (2^-19 g) to velocity (2^-22 m/s): 8*9.80665/2000 in Q16
`define IOU_VEL_K 16'h0A0B
`define IOU_K_SHIFT 16

`endif

// *** logic/iou_delay_mem.v ***
// Purpose: fixed-length sample delay line for the gyro path
// Assumes: one write per sample tick
// Notes: read data is registered; zero until the line has filled
`timescale 1ns/1ps
module iou_delay_mem #(
  parameter WIDTH = 24,
  parameter DEPTH = 10
) (
  input wire sys_clk,
  input wire rst_n,
  input wire wrEn,
  input wire [WIDTH-1:0] wrData,
  output reg [WIDTH-1:0] rdData
);
  localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] ptr_q;
  reg filled_q;

  ////////////////////////////////////////////////////////////////////////
  // write new sample, read the one written DEPTH writes ago
  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[ptr_q] <= wrData;
    end
  end

  // pointer, fill flag and registered read; stale ram hidden until full
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_q <= {PW{1'b0}};
      filled_q <= 1'b0;
      rdData <= {WIDTH{1'b0}};
    end else if (wrEn) begin
      rdData <= filled_q ? mem[ptr_q] : {WIDTH{1'b0}};
      if (ptr_q == DEPTH - 1) begin
        ptr_q <= {PW{1'b0}};
        filled_q <= 1'b1;
      end else begin
        ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // iou_delay_mem

// *** tb/iou_output_unit_asserts.sv ***
// Purpose: port checks of the output-unit block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module iou_output_unit_asserts #(
  parameter int SAMPLE_CYCLES = 25000,
  parameter int DELAY_SAMPLES = 10
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [23:0] gyroSample,
  input wire [23:0] accSample,
  input wire [3:0] gyroUnit,
  input wire accUnit,
  input wire [3:0] lpfShift,
  input wire txStrobe,
  input wire sampleTick_q,
  input wire [23:0] gyroWord_q,
  input wire [23:0] accWord_q,
  input wire wordValid_q,
  input wire [7:0] outByte_q,
  input wire outByteValid_q,
  input wire [2:0] outByteIdx_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] tickGap_q;
  logic seenTick_q;
  wire [47:0] both = {gyroWord_q, accWord_q};
  wire [7:0] expByte = 8'(both >> (8 * (3'h5 - outByteIdx_q)));
  // gap counter, so a long period needs no long repetition
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tickGap_q <= '0;
      seenTick_q <= 1'b0;
    end else begin
      tickGap_q <= sampleTick_q ? '0 : tickGap_q + 1;
      seenTick_q <= seenTick_q | sampleTick_q;
    end
  end
  //////////////////////////////////////////////////////////////////////
  AST_TICK_PERIOD: assert property (sampleTick_q && seenTick_q |->
    tickGap_q == SAMPLE_CYCLES - 1) else $error("tick period wrong");
  AST_TICK_ONE: assert property (sampleTick_q |=> !sampleTick_q)
    else $error("tick longer than one cycle");
  AST_VALID_PULSE: assert property (txStrobe |=> wordValid_q &&
    outByteValid_q && outByteIdx_q == 3'h0) else $error("no word");
  AST_VALID_ONE: assert property (wordValid_q && !txStrobe |=>
    !wordValid_q) else $error("valid stuck");
  AST_BYTE_ORDER: assert property (outByteValid_q |->
    outByte_q == expByte) else $error("byte order wrong");
  AST_IDX_STEP: assert property (outByteValid_q &&
    outByteIdx_q != 3'h5 && !txStrobe |=> outByteValid_q &&
    outByteIdx_q == $past(outByteIdx_q) + 3'h1) else $error("idx skip");
  AST_STREAM_END: assert property (txStrobe ##1 !txStrobe [*6]
    |=> !outByteValid_q) else $error("stream not six bytes");
  AST_WORD_HOLD: assert property (!txStrobe |=>
    $stable(gyroWord_q) && $stable(accWord_q)) else $error("word moved");
  cover property (txStrobe ##1 txStrobe);
  cover property (wordValid_q && gyroWord_q[23]);
  cover property (sampleTick_q && seenTick_q);
endmodule // iou_output_unit_asserts

bind iou_output_unit iou_output_unit_asserts #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .DELAY_SAMPLES(DELAY_SAMPLES)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .gyroSample(gyroSample),
  .accSample(accSample), .gyroUnit(gyroUnit), .accUnit(accUnit),
  .lpfShift(lpfShift), .txStrobe(txStrobe), .sampleTick_q(sampleTick_q),
  .gyroWord_q(gyroWord_q), .accWord_q(accWord_q),
  .wordValid_q(wordValid_q), .outByte_q(outByte_q),
  .outByteValid_q(outByteValid_q), .outByteIdx_q(outByteIdx_q));

// *** tb/iou_host_rx.sv ***
// Purpose: host side that rebuilds the two words from the byte stream
// Assumes: six bytes per transmission, one per cycle
// Notes: a restarted stream simply shifts on
`timescale 1ns/1ps
module iou_host_rx (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] outByte,
  input wire outByteValid,
  input wire [2:0] outByteIdx,
  output logic [23:0] rxGyro,
  output logic [23:0] rxAcc,
  output logic rxDone_q
);
  logic [47:0] shift_q;
  // high byte arrives first, so a left shift rebuilds each word
  always_ff @(posedge sys_clk) begin
    rxDone_q <= 1'b0;
    if (!rst_n) begin
      shift_q <= '0;
    end else if (outByteValid) begin
      shift_q <= {shift_q[39:0], outByte};
      rxDone_q <= (outByteIdx == 3'h5);
    end
  end
  assign rxGyro = shift_q[47:24];
  assign rxAcc = shift_q[23:0];
endmodule // iou_host_rx

// *** tb/tb.sv ***
// Purpose: random and corner tests of the output-unit block
// Assumes: short sample period of 20 cycles, filter passed through except in the filter test
// Notes: delayed codes still see the old value, delay outlasts the wait to the second strobe
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
  logic sys_clk = 0, rst_n = 0, txStrobe = 0, accUnit = 0;
  logic [23:0] gyroSample = '0, accSample = '0;
  logic [3:0] gyroUnit = '0, lpfShift = '0;
  wire sampleTick_q, wordValid_q, outByteValid_q, rxDone_q;
  wire [23:0] gyroWord_q, accWord_q, rxGyro, rxAcc;
  wire [7:0] outByte_q;
  wire [2:0] outByteIdx_q;
  integer seed = 9, fails = 0, cmp_count = 0, i, k;
  logic [23:0] x0, x, a, w1, e, ea;
  iou_output_unit #(.SAMPLE_CYCLES(20), .DELAY_SAMPLES(10)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .gyroSample(gyroSample),
    .accSample(accSample), .gyroUnit(gyroUnit), .accUnit(accUnit),
    .lpfShift(lpfShift), .txStrobe(txStrobe), .sampleTick_q(sampleTick_q),
    .gyroWord_q(gyroWord_q), .accWord_q(accWord_q),
    .wordValid_q(wordValid_q), .outByte_q(outByte_q),
    .outByteValid_q(outByteValid_q), .outByteIdx_q(outByteIdx_q));
  iou_host_rx i_host (.sys_clk(sys_clk), .rst_n(rst_n), .outByte(outByte_q),
    .outByteValid(outByteValid_q), .outByteIdx(outByteIdx_q),
    .rxGyro(rxGyro), .rxAcc(rxAcc), .rxDone_q(rxDone_q));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one-cycle pulse, taken at the edge after the call
  task automatic strobe;
    txStrobe <= 1'b1;
    cyc(1);
    txStrobe <= 1'b0;
  endtask
  // four samples of v scaled by a Q16 factor, floored
  function automatic logic [23:0] incr(input logic [23:0] v, input int q);
    longint s;
    s = 4 * longint'($signed(v)) * q;
    return 24'(s >>> 16);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // every gyro code with both accel codes; strobes 80 cycles apart
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) begin
      // signed modulus, so negative samples reach the design too
      x0 = $random(seed) % 32'sh00100000;
      x = $random(seed) % 32'sh00100000;
      a = $random(seed) % 32'sh00100000;
      gyroSample <= x0;
      gyroUnit <= {i[3], 1'b0, i[1:0]};
      accUnit <= i[2];
      cyc(220);
      gyroSample <= x;
      accSample <= a;
      cyc(60);
      strobe;
      cyc(79);
      w1 = gyroWord_q;
      strobe;
      e = i[3] ? x0 : x;
      e = i[0] ? incr(e, 4194) : e;
      ea = i[2] ? a : incr(a, 2571);
      for (k = 0; k < 20 && rxDone_q !== 1'b1; k++) cyc(1);
      if (k == 20) begin
        fails++;
        final_report;
      end
      if (i[1:0] == 2'h3) `CHK("angle step", 1'b1, 24'(gyroWord_q - w1 - e) <= 1)
      else `CHK("gyro word", e, gyroWord_q)
      if (i[1:0] != 2'h3) `CHK("host gyro", e, rxGyro)
      `CHK("acc word", ea, accWord_q)
      `CHK("host acc", ea, rxAcc)
      $display("test %0d code %h done", i, gyroUnit);
    end
    // second reset clears the running angle
    rst_n <= 1'b0;
    gyroSample <= '0;
    gyroUnit <= 4'h3;
    cyc(2);
    rst_n <= 1'b1;
    cyc(100);
    strobe;
    cyc(8);
    `CHK("angle after reset", 24'h000000, gyroWord_q)
    $display("test reset done");
    // filter from zero: a pass-through would show the full step
    lpfShift <= 4'h1;
    gyroUnit <= 4'h0;
    gyroSample <= 24'h000400;
    cyc(50);
    strobe;
    cyc(8);
    x = 24'h000400 - gyroWord_q;
    `CHK("lpf step", 1'b1, $countones(x) == 1 && x < 24'h000400)
    $display("test filter done");
    final_report;
  end
  // hang guard
  initial begin
    cyc(20000);
    fails++;
    final_report;
  end
endmodule // tb
